// ==== bridge_adc_pkg.sv ====
/*
  constants for the bridge conversion decimator: register offsets,
  field positions, reset values, timing counts, filter scaling.
  assumes a 250 MHz system clock.
*/
package bridge_adc_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MOD_HZ = 1_000_000;
  localparam int unsigned MOD_DIV = CLK_HZ / MOD_HZ;
  localparam int unsigned REF_SETTLE_US = 50;
  localparam int unsigned REF_SETTLE_CYC = REF_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RATE_SHORT_US = 64;
  localparam int unsigned RATE_LONG_US = 128;
  localparam int unsigned DEC_SHORT = RATE_SHORT_US * (MOD_HZ / 1_000_000);
  localparam int unsigned DEC_LONG = RATE_LONG_US * (MOD_HZ / 1_000_000);
  localparam int unsigned ACC_W = 26;
  localparam int unsigned PROD_W = ACC_W + 18;
  // full scale of 7 * R^3 maps just above 2^23, then saturates
  localparam logic signed [17:0] SCALE_K = 18'sh0924a;
  localparam int unsigned SHIFT_LONG = 16;
  localparam int unsigned SHIFT_SHORT = 13;
  localparam logic signed [23:0] RES_MAX = 24'sh7fffff;
  localparam logic signed [23:0] RES_MIN = -24'sh800000;

  localparam logic [7:0] ADDR_RES0 = 8'h00;
  localparam logic [7:0] ADDR_RES1 = 8'h01;
  localparam logic [7:0] ADDR_RES2 = 8'h02;
  localparam logic [7:0] ADDR_CONV_CFG = 8'h03;
  localparam logic [7:0] ADDR_MOD_CFG = 8'h04;
  localparam logic [7:0] ADDR_APWR = 8'h05;
  localparam logic [7:0] ADDR_GAIN = 8'h06;
  localparam logic [7:0] ADDR_FE_CFG = 8'h07;
  localparam logic [7:0] ADDR_BRIDGE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h09;

  localparam int unsigned CFG_EN = 0;
  localparam int unsigned CFG_W24 = 1;
  localparam int unsigned CFG_R128 = 2;
  localparam int unsigned CFG_IRQ4 = 3;
  localparam int unsigned MOD_HALT = 0;
  localparam int unsigned PWR_REFBUF = 0;
  localparam int unsigned PWR_GATE_SD = 1;
  localparam int unsigned FE_DISC = 0;
  localparam int unsigned ST_READY = 0;
  localparam int unsigned ST_REFOK = 1;
  localparam int unsigned ST_RUN = 2;

  localparam logic [3:0] CONV_CFG_RST = 4'h0;
  localparam logic MOD_HALT_RST = 1'b0;
  localparam logic [1:0] APWR_RST = 2'h0;
  localparam logic [4:0] GAIN_RST = 5'h00;
  localparam logic FE_DISC_RST = 1'b0;
  localparam logic [1:0] VSEL_2V5 = 2'h0;
  localparam logic [1:0] VSEL_2V0 = 2'h1;
  localparam logic [1:0] VSEL_1V2 = 2'h2;

  typedef enum logic [1:0] {
    DEC_IDLE = 2'b00,
    DEC_FILL1 = 2'b01,
    DEC_FILL2 = 2'b11,
    DEC_RUN = 2'b10
  } dec_state_t;
endpackage : bridge_adc_pkg

// ==== bridge_adc_decimator.sv ====
/*
  bridge conversion path digital side: modulator pacing, sinc3
  decimator, result bytes, control bits, core reset from supplies.
  assumes clk_sys is the core clock derived from the oscillator,
  mod_code and supply flags arrive asynchronously.
*/
// Notes on behaviour
// RQ1: modulator runs at 1 MHz, each cycle gives a 3-bit code.
// RQ2: halt bit stops modulator samples; clearing it resumes them.
// RQ3: one sample per 64 or 128 us, chosen by configuration.
// RQ4: result is two's complement, 16 or 24 bits wide.
// RQ5: codes linear; full scale saturates to 0x8000/0x800000 and maximum.
// RQ6: decimator enable bit; disabled means no samples and no interrupts.
// RQ7: each sample lands in three byte-wide result registers.
// RQ8: interrupt on every sample or every fourth, per configuration.
// RQ9: core reset held until both supplies regulate; reasserts on dropout.
// RQ10: all timing derives from the one core clock by dividers.
// RQ11: processor ignores results for 50 us after core starts.
// RQ12: reference buffer enable resets to zero; zero turns buffer off.
// RQ13: amplifier gain is a 5-bit field.
// RQ14: processor sets amplifier disconnect on input overvoltage.
// RQ15: bridge supply select picks 2.5 V, 2 V or 1.2 V.
// RQ16: processor sets gate drive shutdown when gate drive unused.
// RQ17: fourth-sample counter restarts whenever decimator is disabled.
`timescale 1ns/1ps
module bridge_adc_decimator #(
  parameter int unsigned REF_SETTLE_CYC = bridge_adc_pkg::REF_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] mod_code,
  input wire logic analog_supply_ok,
  input wire logic digital_supply_ok,
  output logic mod_halt,
  output logic mod_strobe,
  output logic ref_buf_en,
  output logic gate_drive_shutdown,
  output logic [4:0] amp_gain,
  output logic input_amp_disconnect,
  output logic [1:0] bridge_voltage_select,
  output logic core_reset,
  output logic sample_irq
);
  localparam int unsigned AW = bridge_adc_pkg::ACC_W;
  localparam int unsigned PW = bridge_adc_pkg::PROD_W;
  localparam int unsigned REF_W = $clog2(REF_SETTLE_CYC + 1);

  logic [1:0] sup_a_r, sup_d_r;
  logic core_reset_r;
  logic [REF_W-1:0] ref_cnt_r;
  logic ref_valid_r;
  logic [2:0] code_s1_r, code_s2_r;
  logic [7:0] div_cnt_r;
  logic mod_tick_r;
  logic [3:0] conv_cfg_r;
  logic halt_r;
  logic [1:0] apwr_r;
  logic [4:0] gain_r;
  logic disc_r;
  logic [1:0] vsel_r;
  bridge_adc_pkg::dec_state_t st_r;
  logic [6:0] dec_cnt_r;
  logic signed [AW-1:0] i1_r, i2_r, i3_r, d1_r, d2_r, d3_r;
  logic signed [AW-1:0] c1, c2, c3;
  logic signed [4:0] x_in;
  logic signed [PW-1:0] prod, shifted;
  logic signed [23:0] res24;
  logic [23:0] res_r;
  logic [1:0] irq_cnt_r;
  logic irq_r;
  logic ready_r;
  logic [7:0] rdata_r;
  logic dec_last, out_stb, sample_vld, rate_chg, wr_hit_cfg;

  // supply flags and modulator code cross in through two flops
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sup_a_r <= 2'h0;
      sup_d_r <= 2'h0;
      code_s1_r <= 3'h0;
      code_s2_r <= 3'h0;
    end else begin
      sup_a_r <= {sup_a_r[0], analog_supply_ok};
      sup_d_r <= {sup_d_r[0], digital_supply_ok};
      code_s1_r <= mod_code;
      code_s2_r <= code_s1_r;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      core_reset_r <= 1'b1;
    end else begin
      core_reset_r <= ~(sup_a_r[1] & sup_d_r[1]); // [RQ9]
    end
  end

  // reference settle timer from core start
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ref_cnt_r <= '0;
      ref_valid_r <= 1'b0;
    end else if (core_reset_r) begin
      ref_cnt_r <= '0;
      ref_valid_r <= 1'b0;
    end else if (!ref_valid_r) begin
      ref_cnt_r <= ref_cnt_r + REF_W'(1);
      ref_valid_r <= (ref_cnt_r == REF_W'(REF_SETTLE_CYC - 1)); // [RQ11]
    end
  end

  // 1 MHz modulator pacing
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_r <= 8'h00;
      mod_tick_r <= 1'b0;
    end else begin
      div_cnt_r <= (div_cnt_r == 8'(bridge_adc_pkg::MOD_DIV - 1)) ? 8'h00 : div_cnt_r + 8'h01; // [RQ10]
      mod_tick_r <= (div_cnt_r == 8'(bridge_adc_pkg::MOD_DIV - 1)) && !halt_r && !core_reset_r; // [RQ1] [RQ2]
    end
  end

  assign wr_hit_cfg = reg_wr && (reg_addr == bridge_adc_pkg::ADDR_CONV_CFG);
  assign rate_chg = wr_hit_cfg && (reg_wdata[bridge_adc_pkg::CFG_R128] != conv_cfg_r[bridge_adc_pkg::CFG_R128]);

  // software-written control registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      conv_cfg_r <= bridge_adc_pkg::CONV_CFG_RST;
      halt_r <= bridge_adc_pkg::MOD_HALT_RST;
      apwr_r <= bridge_adc_pkg::APWR_RST; // [RQ12]
      gain_r <= bridge_adc_pkg::GAIN_RST;
      disc_r <= bridge_adc_pkg::FE_DISC_RST;
      vsel_r <= bridge_adc_pkg::VSEL_2V5;
    end else if (reg_wr) begin
      unique case (reg_addr)
        bridge_adc_pkg::ADDR_CONV_CFG: conv_cfg_r <= reg_wdata[3:0];
        bridge_adc_pkg::ADDR_MOD_CFG: halt_r <= reg_wdata[bridge_adc_pkg::MOD_HALT]; // [RQ2]
        bridge_adc_pkg::ADDR_APWR: apwr_r <= reg_wdata[1:0]; // [RQ12] [RQ16]
        bridge_adc_pkg::ADDR_GAIN: gain_r <= reg_wdata[4:0]; // [RQ13]
        bridge_adc_pkg::ADDR_FE_CFG: disc_r <= reg_wdata[bridge_adc_pkg::FE_DISC]; // [RQ14]
        bridge_adc_pkg::ADDR_BRIDGE: begin
          if (reg_wdata[1:0] != 2'h3) begin
            vsel_r <= reg_wdata[1:0]; // [RQ15]
          end
        end
        default: ;
      endcase
    end
  end

  // sinc3 decimator
  assign x_in = $signed({1'b0, code_s2_r, 1'b0}) - 5'sd7;
  assign dec_last = dec_cnt_r == (conv_cfg_r[bridge_adc_pkg::CFG_R128]
                    ? 7'(bridge_adc_pkg::DEC_LONG - 1) : 7'(bridge_adc_pkg::DEC_SHORT - 1));
  assign out_stb = mod_tick_r && dec_last && (st_r != bridge_adc_pkg::DEC_IDLE); // [RQ3]
  assign sample_vld = out_stb && (st_r == bridge_adc_pkg::DEC_RUN) && conv_cfg_r[bridge_adc_pkg::CFG_EN]; // [RQ6]
  assign c1 = i3_r - d1_r;
  assign c2 = c1 - d2_r;
  assign c3 = c2 - d3_r;
  assign prod = PW'(c3) * PW'(bridge_adc_pkg::SCALE_K);
  assign shifted = conv_cfg_r[bridge_adc_pkg::CFG_R128]
                   ? (prod >>> bridge_adc_pkg::SHIFT_LONG) : (prod >>> bridge_adc_pkg::SHIFT_SHORT);

  always_comb begin
    if (shifted > PW'(bridge_adc_pkg::RES_MAX)) begin
      res24 = bridge_adc_pkg::RES_MAX; // [RQ5]
    end else if (shifted < PW'(bridge_adc_pkg::RES_MIN)) begin
      res24 = bridge_adc_pkg::RES_MIN; // [RQ5]
    end else begin
      res24 = shifted[23:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= bridge_adc_pkg::DEC_IDLE;
    end else if (!conv_cfg_r[bridge_adc_pkg::CFG_EN] || core_reset_r || rate_chg) begin
      st_r <= bridge_adc_pkg::DEC_IDLE; // [RQ6]
    end else begin
      unique case (st_r)
        bridge_adc_pkg::DEC_IDLE: st_r <= bridge_adc_pkg::DEC_FILL1;
        bridge_adc_pkg::DEC_FILL1: if (out_stb) st_r <= bridge_adc_pkg::DEC_FILL2;
        bridge_adc_pkg::DEC_FILL2: if (out_stb) st_r <= bridge_adc_pkg::DEC_RUN;
        bridge_adc_pkg::DEC_RUN: st_r <= bridge_adc_pkg::DEC_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dec_cnt_r <= 7'h00;
      {i1_r, i2_r, i3_r, d1_r, d2_r, d3_r} <= '0;
    end else if (st_r == bridge_adc_pkg::DEC_IDLE) begin
      dec_cnt_r <= 7'h00;
      {i1_r, i2_r, i3_r, d1_r, d2_r, d3_r} <= '0;
    end else if (mod_tick_r) begin
      i1_r <= i1_r + AW'(x_in);
      i2_r <= i2_r + i1_r;
      i3_r <= i3_r + i2_r;
      dec_cnt_r <= dec_last ? 7'h00 : dec_cnt_r + 7'h01; // [RQ3]
      if (dec_last) begin
        d1_r <= i3_r;
        d2_r <= c1;
        d3_r <= c2;
      end
    end
  end

  // result bytes, 16-bit mode sign-extends into the top byte
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      res_r <= 24'h000000;
    end else if (sample_vld) begin
      res_r <= conv_cfg_r[bridge_adc_pkg::CFG_W24] ? res24 : {{8{res24[23]}}, res24[23:8]}; // [RQ4] [RQ7]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_cnt_r <= 2'h0;
      irq_r <= 1'b0;
    end else if (st_r == bridge_adc_pkg::DEC_IDLE) begin
      irq_cnt_r <= 2'h0; // [RQ17]
      irq_r <= 1'b0; // [RQ6]
    end else begin
      irq_r <= sample_vld && (!conv_cfg_r[bridge_adc_pkg::CFG_IRQ4] || irq_cnt_r == 2'h3); // [RQ8]
      if (sample_vld) begin
        irq_cnt_r <= irq_cnt_r + 2'h1;
      end
    end
  end

  // ready flag: a new sample wins over a read of the low byte
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ready_r <= 1'b0;
    end else if (sample_vld) begin
      ready_r <= 1'b1;
    end else if (reg_rd && reg_addr == bridge_adc_pkg::ADDR_RES0) begin
      ready_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (!reg_rd) begin
      rdata_r <= 8'h00;
    end else begin
      unique case (reg_addr)
        bridge_adc_pkg::ADDR_RES0: rdata_r <= res_r[7:0]; // [RQ7]
        bridge_adc_pkg::ADDR_RES1: rdata_r <= res_r[15:8];
        bridge_adc_pkg::ADDR_RES2: rdata_r <= res_r[23:16];
        bridge_adc_pkg::ADDR_CONV_CFG: rdata_r <= {4'h0, conv_cfg_r};
        bridge_adc_pkg::ADDR_MOD_CFG: rdata_r <= {7'h00, halt_r};
        bridge_adc_pkg::ADDR_APWR: rdata_r <= {6'h00, apwr_r};
        bridge_adc_pkg::ADDR_GAIN: rdata_r <= {3'h0, gain_r};
        bridge_adc_pkg::ADDR_FE_CFG: rdata_r <= {7'h00, disc_r};
        bridge_adc_pkg::ADDR_BRIDGE: rdata_r <= {6'h00, vsel_r};
        bridge_adc_pkg::ADDR_STATUS: rdata_r <= {5'h00, st_r == bridge_adc_pkg::DEC_RUN, ref_valid_r, ready_r};
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_r;
  assign mod_halt = halt_r;
  assign mod_strobe = mod_tick_r;
  assign ref_buf_en = apwr_r[bridge_adc_pkg::PWR_REFBUF];
  assign gate_drive_shutdown = apwr_r[bridge_adc_pkg::PWR_GATE_SD];
  assign amp_gain = gain_r;
  assign input_amp_disconnect = disc_r;
  assign bridge_voltage_select = vsel_r;
  assign core_reset = core_reset_r;
  assign sample_irq = irq_r;

  // samples counted since the last interrupt, for checking only
  logic [2:0] since_irq_r;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      since_irq_r <= 3'h0;
    end else if (st_r == bridge_adc_pkg::DEC_IDLE || irq_r) begin
      since_irq_r <= sample_vld ? 3'h1 : 3'h0;
    end else if (sample_vld) begin
      since_irq_r <= since_irq_r + 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_halt_stops_tick: assert property (mod_halt |=> !mod_strobe) // [RQ2]
    else $error("modulator strobe while halted");
  chk_tick_spacing: assert property (mod_strobe |=> (!mod_strobe)[*8]) // [RQ10]
    else $error("modulator strobes too close");
  chk_sample_spacing: assert property (sample_vld |=> (!sample_vld)[*8]) // [RQ3]
    else $error("samples too close");
  chk_disabled_quiet: assert property (!conv_cfg_r[bridge_adc_pkg::CFG_EN] |=> !sample_irq && !sample_vld) // [RQ6]
    else $error("activity while decimator disabled");
  chk_irq_cause: assert property (sample_irq |-> $past(sample_vld)) // [RQ8]
    else $error("interrupt without sample");
  chk_irq_fourth: assert property (sample_irq && conv_cfg_r[bridge_adc_pkg::CFG_IRQ4] |-> since_irq_r == 3'h4) // [RQ17]
    else $error("fourth-sample interrupt miscounted");
  chk_supply_reset: assert property (!(sup_a_r[1] && sup_d_r[1]) |=> core_reset) // [RQ9]
    else $error("core reset released early");
  chk_width16_sign: assert property (sample_vld && !conv_cfg_r[bridge_adc_pkg::CFG_W24]
    |=> res_r[23:16] == {8{res_r[15]}}) // [RQ4]
    else $error("16-bit result not sign extended");
  chk_zero_code: assert property (sample_vld && c3 == '0 |=> res_r == 24'h000000) // [RQ5]
    else $error("zero input gave nonzero result");

  cov_every_sample: cover property (sample_irq && !conv_cfg_r[bridge_adc_pkg::CFG_IRQ4]);
  cov_fourth_irq: cover property (sample_irq && conv_cfg_r[bridge_adc_pkg::CFG_IRQ4]);
  cov_saturate: cover property (sample_vld && res24 == bridge_adc_pkg::RES_MAX);
  cov_ref_valid: cover property ($rose(ref_valid_r));
endmodule : bridge_adc_decimator

// ==== bridge_front_model.sv ====
/*
  partner model of the bridge modulator: presents a chosen 3-bit code
  at each modulator tick.
  assumes clk_sys and mod_strobe come from the decimator under test.
*/
`timescale 1ns/1ps
module bridge_front_model (
  input wire logic clk_sys,
  input wire logic mod_strobe,
  input wire logic mod_halt,
  input wire logic [2:0] level,
  output logic [2:0] mod_code
);
  initial mod_code = 3'h3;
  // new code on each tick, frozen while halted
  always @(posedge clk_sys) begin
    if (mod_strobe && !mod_halt) begin
      mod_code <= level;
    end
  end
endmodule : bridge_front_model

// ==== test_bridge_adc_decimator.sv ====
/*
  self-checking bench for the bridge decimator: registers, supplies,
  modulator pacing and halt, full-scale samples and their period.
  assumes a 250 MHz clock and a settle count shortened to 20.
*/
`timescale 1ns/1ps
module test_bridge_adc_decimator;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] mod_code;
  logic [2:0] level = 3'h7;
  logic analog_supply_ok = 1'b0;
  logic digital_supply_ok = 1'b0;
  logic mod_halt, mod_strobe, ref_buf_en, gate_drive_shutdown;
  logic [4:0] amp_gain;
  logic input_amp_disconnect;
  logic [1:0] bridge_voltage_select;
  logic core_reset, sample_irq;
  int err_count = 0;
  int total_checks = 0;
  int n;
  logic [7:0] v;
  time irq_t[$];

  always #2 clk_sys = ~clk_sys;

  bridge_adc_decimator #(.REF_SETTLE_CYC(20)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_code(mod_code),
    .analog_supply_ok(analog_supply_ok), .digital_supply_ok(digital_supply_ok),
    .mod_halt(mod_halt), .mod_strobe(mod_strobe), .ref_buf_en(ref_buf_en),
    .gate_drive_shutdown(gate_drive_shutdown), .amp_gain(amp_gain),
    .input_amp_disconnect(input_amp_disconnect), .bridge_voltage_select(bridge_voltage_select),
    .core_reset(core_reset), .sample_irq(sample_irq)
  );

  bridge_front_model u_front (
    .clk_sys(clk_sys), .mod_strobe(mod_strobe), .mod_halt(mod_halt), .level(level), .mod_code(mod_code)
  );

  always @(negedge clk_sys) begin
    if (sample_irq === 1'b1) begin
      irq_t.push_back($time);
    end
  end

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // bounded wait for a core_reset level, counts a mismatch on expiry
  task automatic wait_core(input logic lvl, input int bound);
    n = 0;
    while (core_reset !== lvl && n < bound) begin
      @(negedge clk_sys);
      n++;
    end
    if (core_reset !== lvl) begin
      err_count++;
      wrap_up();
    end
  endtask : wait_core

  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check("core_reset none", core_reset, 24'h1);
    analog_supply_ok <= 1'b1;
    repeat (10) @(posedge clk_sys);
    check("core_reset one", core_reset, 24'h1);
    digital_supply_ok <= 1'b1;
    wait_core(1'b0, 10);
    rd(bridge_adc_pkg::ADDR_STATUS, v);
    check("ref early", v[bridge_adc_pkg::ST_REFOK], 24'h0);
    repeat (30) @(posedge clk_sys);
    rd(bridge_adc_pkg::ADDR_STATUS, v);
    check("ref valid", v[bridge_adc_pkg::ST_REFOK], 24'h1);
    $display("test supplies done");

    for (int a = 3; a <= 10; a++) begin
      rd(8'(a), v);
      check("reset value", v, (8'(a) == bridge_adc_pkg::ADDR_STATUS) ? 24'h02 : 24'h00);
    end
    wr(bridge_adc_pkg::ADDR_APWR, 8'h03);
    check("ref_buf_en on", ref_buf_en, 24'h1);
    check("gate shutdown", gate_drive_shutdown, 24'h1);
    wr(bridge_adc_pkg::ADDR_APWR, 8'h02);
    check("ref_buf_en off", ref_buf_en, 24'h0);
    wr(bridge_adc_pkg::ADDR_GAIN, 8'h15);
    rd(bridge_adc_pkg::ADDR_GAIN, v);
    check("gain read", v, 24'h15);
    check("gain pin", amp_gain, 24'h15);
    @(posedge clk_sys);
    #1 check("rdata cleared", reg_rdata, 24'h0);
    wr(bridge_adc_pkg::ADDR_FE_CFG, 8'h01);
    check("disconnect", input_amp_disconnect, 24'h1);
    for (int s = 0; s < 3; s++) begin
      wr(bridge_adc_pkg::ADDR_BRIDGE, 8'(s));
      check("vsel", bridge_voltage_select, 24'(s));
    end
    wr(bridge_adc_pkg::ADDR_BRIDGE, 8'h03);
    check("vsel 3 ignored", bridge_voltage_select, 24'h2);
    $display("test registers done");

    // modulator pacing, then halt and resume
    n = 0;
    while (mod_strobe !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    n = 1;
    while (mod_strobe !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check("tick period", 24'(n), 24'd250);
    wr(bridge_adc_pkg::ADDR_MOD_CFG, 8'h01);
    check("halt pin", mod_halt, 24'h1);
    n = 0;
    repeat (600) begin
      @(negedge clk_sys);
      n += int'(mod_strobe === 1'b1);
    end
    check("ticks halted", 24'(n), 24'd0);
    wr(bridge_adc_pkg::ADDR_MOD_CFG, 8'h00);
    n = 0;
    repeat (260) begin
      @(negedge clk_sys);
      n += int'(mod_strobe === 1'b1);
    end
    check("ticks resumed", 24'(n), 24'd1);
    $display("test modulator done");

    // 24-bit, 64 us, irq every sample, full-scale input
    wr(bridge_adc_pkg::ADDR_CONV_CFG, 8'h03);
    n = 0;
    while (irq_t.size() < 1 && n < 50000) begin
      @(negedge clk_sys);
      n++;
    end
    check("first sample", 24'(irq_t.size()), 24'd1);
    rd(bridge_adc_pkg::ADDR_STATUS, v);
    check("new sample", v[bridge_adc_pkg::ST_READY], 24'h1);
    rd(bridge_adc_pkg::ADDR_RES0, v);
    check("res0 24", v, 24'hff);
    rd(bridge_adc_pkg::ADDR_RES1, v);
    check("res1 24", v, 24'hff);
    rd(bridge_adc_pkg::ADDR_RES2, v);
    check("res2 24", v, 24'h7f);
    rd(bridge_adc_pkg::ADDR_STATUS, v);
    check("sample taken", v[bridge_adc_pkg::ST_READY], 24'h0);
    wr(bridge_adc_pkg::ADDR_CONV_CFG, 8'h01);
    n = 0;
    while (irq_t.size() < 2 && n < 17000) begin
      @(negedge clk_sys);
      n++;
    end
    check("second sample", 24'(irq_t.size()), 24'd2);
    if (irq_t.size() >= 2) begin
      check("sample period", 24'((irq_t[1] - irq_t[0]) / 4), 24'd16000);
    end
    rd(bridge_adc_pkg::ADDR_RES0, v);
    check("res0 16", v, 24'hff);
    rd(bridge_adc_pkg::ADDR_RES1, v);
    check("res1 16", v, 24'h7f);
    rd(bridge_adc_pkg::ADDR_RES2, v);
    check("res2 16", v, 24'h00);
    // every-fourth mode: third sample since enable stays silent
    wr(bridge_adc_pkg::ADDR_CONV_CFG, 8'h09);
    repeat (16500) @(posedge clk_sys);
    check("no irq third", 24'(irq_t.size()), 24'd2);
    rd(bridge_adc_pkg::ADDR_STATUS, v);
    check("third sample", v[bridge_adc_pkg::ST_READY], 24'h1);
    check("running", v[bridge_adc_pkg::ST_RUN], 24'h1);
    $display("test samples done");

    wr(bridge_adc_pkg::ADDR_CONV_CFG, 8'h00);
    repeat (16000) @(posedge clk_sys);
    check("no irq disabled", 24'(irq_t.size()), 24'd2);
    digital_supply_ok <= 1'b0;
    wait_core(1'b1, 10);
    check("core_reset drop", core_reset, 24'h1);
    $display("test disable done");
    wrap_up();
  end
endmodule : test_bridge_adc_decimator
